/* logic/fsdb_compose.v */
/*
 fsdb_compose: combinational packing of the 32-byte fixed-format sense
 record from already decided field values; byte n sits in rec[8n+7:8n].
 assumes the caller has settled validity, response code and key legality.
*/
`timescale 1ns/10ps
`include "fsdb_defs.vh"

module fsdb_compose (
   input wire info_valid,          // information field holds a valid value
   input wire [6:0] resp_code,     // 70h current or 71h deferred
   input wire mismatch,            // length mismatch flag
   input wire [3:0] sense_key,     // legal sense key
   input wire [31:0] info,         // block address or residue
   input wire [7:0] asc,           // additional sense code
   input wire [7:0] ascq,          // additional sense code qualifier
   input wire ksv,                 // key_specific_valid
   input wire [22:0] kspec,        // key-specific bits and bytes
   input wire [31:0] vendor,       // vendor error detail
   output wire [255:0] rec         // packed record
);

   // information bytes are zero whenever the valid flag is clear
   wire [31:0] info_out;
   assign info_out = info_valid ? info : 32'h00000000; // [R12]

   // byte order: most significant byte first in the multi-byte fields
   assign rec[7:0] = {info_valid, resp_code}; // [R02] [R03]
   assign rec[15:8] = 8'h00; // [R20]
   assign rec[23:16] = {2'b00, mismatch, 1'b0, sense_key}; // [R05] [R08] [R20]
   assign rec[31:24] = info_out[31:24]; // [R07] [R13]
   assign rec[39:32] = info_out[23:16];
   assign rec[47:40] = info_out[15:8];
   assign rec[55:48] = info_out[7:0];
   assign rec[63:56] = `FSDB_ADD_LEN; // [R16]
   assign rec[95:64] = 32'h00000000; // [R17]
   assign rec[103:96] = asc; // [R18]
   assign rec[111:104] = ascq; // [R18]
   assign rec[119:112] = 8'h00; // [R20]
   assign rec[127:120] = {ksv, kspec[22:16]}; // [R19]
   assign rec[135:128] = kspec[15:8];
   assign rec[143:136] = kspec[7:0];
   assign rec[159:144] = 16'h0000; // [R20]
   assign rec[167:160] = vendor[31:24]; // [R19]
   assign rec[175:168] = vendor[23:16];
   assign rec[183:176] = vendor[15:8];
   assign rec[191:184] = vendor[7:0];
   // command specific bytes 24-29 carry nothing here; 30-31 reserved
   assign rec[239:192] = 48'h000000000000;
   assign rec[255:240] = 16'h0000; // [R20]

endmodule

/* logic/fsdb_defs.vh */
/*
 constants of the fixed-format sense data builder: register offsets,
 field positions, record byte layout, codes and ahb encodings.
 assumes it is included by bare name from the design files under logic/.
*/
`ifndef FSDB_DEFS_VH
`define FSDB_DEFS_VH

// ===================================================
// register byte offsets (haddr[7:0])
`define FSDB_A_CFG      8'h00
`define FSDB_A_INFO_LO  8'h04
`define FSDB_A_INFO_HI  8'h08
`define FSDB_A_LEN      8'h0c
`define FSDB_A_CODE     8'h10
`define FSDB_A_KSPEC    8'h14
`define FSDB_A_VENDOR   8'h18
`define FSDB_A_CMD_LBA  8'h1c
`define FSDB_A_CTRL     8'h20
`define FSDB_A_STATUS   8'h24
`define FSDB_A_CMD_BLKS 8'h28
`define FSDB_A_REC_LO   8'h40
`define FSDB_A_REC_HI   8'h5c

// ===================================================
// cfg register fields
`define FSDB_CFG_KEY_HI     3
`define FSDB_CFG_KEY_LO     0
`define FSDB_CFG_DEFER      4
`define FSDB_CFG_PRIOR_GOOD 5
`define FSDB_CFG_INFO_VLD   6
`define FSDB_CFG_CDB_ILL    7
`define FSDB_CFG_OP_HI      15
`define FSDB_CFG_OP_LO      8

// ctrl and status fields
`define FSDB_CTRL_BUILD     0
`define FSDB_ST_READY       0
`define FSDB_ST_BUSY        1
`define FSDB_ST_KEY_SUBST   2
`define FSDB_ST_OVERFLOW    3
`define FSDB_ST_OUT_RANGE   4
`define FSDB_ST_REFUSED     5

// ===================================================
// record layout
`define FSDB_REC_LAST       5'd31
`define FSDB_RESP_CURRENT   7'h70
`define FSDB_RESP_DEFERRED  7'h71
`define FSDB_ADD_LEN        8'h18
`define FSDB_OP_READ_LONG   8'h3e
`define FSDB_OP_WRITE_LONG  8'h3f
`define FSDB_OP_REASSIGN    8'h07

// sense keys
`define FSDB_KEY_NO_SENSE   4'h0
`define FSDB_KEY_HW_ERROR   4'h4
`define FSDB_KEY_ILLEGAL    4'h5
`define FSDB_KEY_NOT_USED8  4'h8
`define FSDB_KEY_NOT_USEDA  4'ha
`define FSDB_KEY_NOT_IMPLC  4'hc
`define FSDB_KEY_NOT_IMPLD  4'hd
`define FSDB_KEY_RESERVED   4'hf

// ahb encodings
`define FSDB_HTRANS_NONSEQ  2'b10
`define FSDB_HTRANS_SEQ     2'b11
`define FSDB_HSIZE_WORD     3'b010

`endif

/* logic/fsdb_top.v */
/*
 fsdb_top: fixed-format sense data builder with an ahb-lite register
 slave and a byte stream that carries each built record to the transport.
 assumes one 200 MHz clock, inputs synchronous to it, a single ahb master
 doing single word transfers, and hready of the bus equal to hreadyout.
*/
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "fsdb_defs.vh"

// Summary of operation
// [R01] each built record is exactly 32 bytes, streamed and readable.
// [R02] valid flag set only when information bytes hold a defined value.
// [R03] response code 70h for current errors, 71h for deferred errors.
// [R04] deferred code only when the earlier command already returned good status.
// [R05] length mismatch flag only for long read 3Eh and long write 3Fh.
// [R06] length differs on a long command: mismatch and valid both set.
// [R07] on mismatch, information bytes carry requested minus medium length, two's complement.
// [R08] sense key in byte 2 bits 3-0, codes 0h to 4h.
// [R09] keys 5h, 6h, 7h, Bh, Eh for their listed conditions.
// [R10] keys 8h, Ah, Ch, Dh, Fh never emitted; 9h vendor use allowed.
// [R11] illegal field in command block gives key 5h and medium stays untouched.
// [R12] valid flag clear means information bytes all zero.
// [R13] valid address without mismatch lies within the failing command's range.
// [R14] block reassignment 07h may report an address outside the command range.
// [R15] value wider than four bytes clears the valid flag.
// [R16] byte 7 always 18h.
// [R17] bytes 8 to 11 always zero.
// [R18] additional sense code in byte 12, qualifier in byte 13.
// [R19] vendor detail bytes 20-23, key_specific_valid byte 15 bit 7, content 15-17.
// [R20] bytes 1, 14, 18, 19, 30, 31 and byte 2 bits 7, 6, 4 are zero.
module fsdb_top (
   input wire clk, // 200 MHz clock
   input wire rst, // asynchronous reset, active high
   input wire hsel, // ahb slave select
   input wire [31:0] haddr, // ahb address
   input wire [1:0] htrans, // ahb transfer type
   input wire hwrite, // ahb write
   input wire [2:0] hsize, // ahb size, word only
   input wire [31:0] hwdata, // ahb write data
   input wire hready, // ahb bus ready
   output wire hreadyout, // ahb slave ready
   output wire hresp, // ahb response, always okay
   output reg [31:0] hrdata, // ahb read data
   output wire [7:0] sense_byte, // record byte on the stream
   output wire sense_valid, // stream byte valid
   output wire sense_last, // last byte of the record
   input wire sense_ready, // transport accepts the byte
   output reg medium_hold // blocks medium writes for the failed command
);

   // ===================================================
   // decode helpers

   // keys that may never leave the block
   function key_forbidden;
      input [3:0] key;
      begin
         key_forbidden = (key == `FSDB_KEY_NOT_USED8) || (key == `FSDB_KEY_NOT_USEDA) ||
            (key == `FSDB_KEY_NOT_IMPLC) || (key == `FSDB_KEY_NOT_IMPLD) ||
            (key == `FSDB_KEY_RESERVED);
      end
   endfunction

   // long read or long write opcode
   function is_long_op;
      input [7:0] op;
      begin
         is_long_op = (op == `FSDB_OP_READ_LONG) || (op == `FSDB_OP_WRITE_LONG);
      end
   endfunction

   // ===================================================
   // ahb-lite slave front end

   reg dp_write; // data phase pending: write
   reg dp_read; // data phase pending: read
   reg [7:0] dp_addr; // address held for the data phase
   reg rd_wait; // read data is being fetched
   wire addr_take;

   // a transfer is taken when selected, active, and the bus is ready
   assign addr_take = hsel && hready &&
      ((htrans == `FSDB_HTRANS_NONSEQ) || (htrans == `FSDB_HTRANS_SEQ));

   // reads stretch one cycle so hrdata comes from a flop after any write lands
   assign hreadyout = ~(dp_read && rd_wait);
   assign hresp = 1'b0;

   // address phase capture
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 8'h00;
         rd_wait <= 1'b0;
      end else begin
         if (hreadyout) begin
            dp_write <= addr_take && hwrite;
            dp_read <= addr_take && !hwrite;
            rd_wait <= addr_take && !hwrite;
            if (addr_take) begin
               dp_addr <= haddr[7:0];
            end
         end else begin
            rd_wait <= 1'b0;
         end
      end
   end

   // ===================================================
   // software-written fields

   reg [15:0] cfg; // key, defer, prior good, info valid, cdb illegal, opcode
   reg [31:0] info_lo; // information value, low word
   reg [31:0] info_hi; // information value, high word
   reg [31:0] len; // requested [15:0], medium [31:16] block length
   reg [15:0] code; // asc [7:0], ascq [15:8]
   reg [23:0] kspec_reg; // ksv [23], key-specific content [22:0]
   reg [31:0] vendor; // vendor error detail
   reg [31:0] cmd_lba; // first block of the failing command
   reg [31:0] cmd_blks; // block count of the failing command
   wire wr_en;
   wire build_req;

   assign wr_en = dp_write;
   assign build_req = wr_en && (dp_addr == `FSDB_A_CTRL) && hwdata[`FSDB_CTRL_BUILD];

   // register writes in the data phase
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg <= 16'h0000;
         info_lo <= 32'h00000000;
         info_hi <= 32'h00000000;
         len <= 32'h00000000;
         code <= 16'h0000;
         kspec_reg <= 24'h000000;
         vendor <= 32'h00000000;
         cmd_lba <= 32'h00000000;
         cmd_blks <= 32'h00000000;
      end else if (wr_en) begin
         case (dp_addr)
            `FSDB_A_CFG: begin
               cfg <= hwdata[15:0];
            end
            `FSDB_A_INFO_LO: begin
               info_lo <= hwdata;
            end
            `FSDB_A_INFO_HI: begin
               info_hi <= hwdata;
            end
            `FSDB_A_LEN: begin
               len <= hwdata;
            end
            `FSDB_A_CODE: begin
               code <= hwdata[15:0];
            end
            `FSDB_A_KSPEC: begin
               kspec_reg <= hwdata[23:0];
            end
            `FSDB_A_VENDOR: begin
               vendor <= hwdata;
            end
            `FSDB_A_CMD_LBA: begin
               cmd_lba <= hwdata;
            end
            `FSDB_A_CMD_BLKS: begin
               cmd_blks <= hwdata;
            end
            default: begin
            end
         endcase
      end
   end

   // ===================================================
   // field decisions

   wire [7:0] opcode;
   wire [3:0] key_in;
   wire long_op;
   wire mismatch;
   wire [31:0] residue;
   wire overflow;
   wire [32:0] range_end;
   wire in_range;
   wire addr_ok;
   wire key_bad;
   wire [3:0] key_out;
   wire deferred;
   wire info_valid;
   wire [31:0] info_sel;
   wire [255:0] rec_next;

   assign opcode = cfg[`FSDB_CFG_OP_HI:`FSDB_CFG_OP_LO];
   assign key_in = cfg[`FSDB_CFG_KEY_HI:`FSDB_CFG_KEY_LO];
   assign long_op = is_long_op(opcode);

   // mismatch exists only on long commands whose lengths differ
   assign mismatch = long_op && (len[15:0] != len[31:16]); // [R05] [R06]
   assign residue = {16'h0000, len[15:0]} - {16'h0000, len[31:16]}; // [R07]

   // address too wide for four bytes
   assign overflow = !mismatch && (info_hi != 32'h00000000); // [R15]

   // address must fall inside the command's span, reassignment excepted
   assign range_end = {1'b0, cmd_lba} + {1'b0, cmd_blks};
   assign in_range = ({1'b0, info_lo} >= {1'b0, cmd_lba}) && ({1'b0, info_lo} < range_end);
   assign addr_ok = in_range || (opcode == `FSDB_OP_REASSIGN); // [R13] [R14]

   // an illegal field in the command block forces the illegal request key
   assign key_bad = !cfg[`FSDB_CFG_CDB_ILL] && key_forbidden(key_in);
   assign key_out = cfg[`FSDB_CFG_CDB_ILL] ? `FSDB_KEY_ILLEGAL : // [R11]
      (key_bad ? `FSDB_KEY_HW_ERROR : key_in); // [R08] [R09] [R10]

   // deferred only for an error of a command that already completed good
   assign deferred = cfg[`FSDB_CFG_DEFER] && cfg[`FSDB_CFG_PRIOR_GOOD]; // [R04]

   assign info_valid = mismatch || // [R06]
      (cfg[`FSDB_CFG_INFO_VLD] && !overflow && addr_ok); // [R02] [R13] [R15]
   assign info_sel = mismatch ? residue : info_lo; // [R07]

   fsdb_compose u_compose (
      .info_valid(info_valid),
      .resp_code(deferred ? `FSDB_RESP_DEFERRED : `FSDB_RESP_CURRENT), // [R03]
      .mismatch(mismatch),
      .sense_key(key_out),
      .info(info_sel),
      .asc(code[7:0]),
      .ascq(code[15:8]),
      .ksv(kspec_reg[23]),
      .kspec(kspec_reg[22:0]),
      .vendor(vendor),
      .rec(rec_next)
   );

   // ===================================================
   // record store and byte stream

   reg [255:0] rec; // last built record
   reg [4:0] idx; // byte being offered
   reg busy; // stream in progress
   reg ready_flag; // a record has been built
   reg st_subst; // forbidden key was replaced by hardware error
   reg st_overflow; // valid dropped for a wide value
   reg st_range; // valid dropped for an address out of range
   reg st_refused; // build asked while streaming
   wire build_go;

   // a build during a stream is refused so the record in flight stays whole
   assign build_go = build_req && !busy;

   assign sense_valid = busy;
   assign sense_byte = rec[{idx, 3'b000} +: 8];
   assign sense_last = busy && (idx == `FSDB_REC_LAST); // [R01]

   // latch the record and walk its 32 bytes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rec <= 256'h0;
         idx <= 5'd0;
         busy <= 1'b0;
         ready_flag <= 1'b0;
         st_subst <= 1'b0;
         st_overflow <= 1'b0;
         st_range <= 1'b0;
         st_refused <= 1'b0;
         medium_hold <= 1'b0;
      end else begin
         if (build_go) begin
            rec <= rec_next; // [R01]
            idx <= 5'd0;
            busy <= 1'b1;
            ready_flag <= 1'b1;
            st_subst <= key_bad; // [R10]
            st_overflow <= cfg[`FSDB_CFG_INFO_VLD] && overflow;
            st_range <= cfg[`FSDB_CFG_INFO_VLD] && !mismatch && !addr_ok;
            medium_hold <= cfg[`FSDB_CFG_CDB_ILL]; // [R11]
         end else if (busy && sense_ready) begin
            idx <= idx + 5'd1;
            if (idx == `FSDB_REC_LAST) begin
               busy <= 1'b0;
            end
         end
         // refusal is sticky; a status read clears it, a new refusal wins
         if (build_req && busy) begin
            st_refused <= 1'b1;
         end else if (dp_read && !rd_wait && (dp_addr == `FSDB_A_STATUS)) begin
            st_refused <= 1'b0;
         end
      end
   end

   // ===================================================
   // read data

   reg [31:0] next_rdata;
   wire [2:0] word_sel;

   assign word_sel = dp_addr[4:2];

   // read mux; unmapped offsets read zero
   always @* begin
      next_rdata = 32'h00000000;
      case (dp_addr)
         `FSDB_A_CFG: next_rdata = {16'h0000, cfg};
         `FSDB_A_INFO_LO: next_rdata = info_lo;
         `FSDB_A_INFO_HI: next_rdata = info_hi;
         `FSDB_A_LEN: next_rdata = len;
         `FSDB_A_CODE: next_rdata = {16'h0000, code};
         `FSDB_A_KSPEC: next_rdata = {8'h00, kspec_reg};
         `FSDB_A_VENDOR: next_rdata = vendor;
         `FSDB_A_CMD_LBA: next_rdata = cmd_lba;
         `FSDB_A_CMD_BLKS: next_rdata = cmd_blks;
         `FSDB_A_STATUS: begin
            next_rdata[`FSDB_ST_READY] = ready_flag;
            next_rdata[`FSDB_ST_BUSY] = busy;
            next_rdata[`FSDB_ST_KEY_SUBST] = st_subst;
            next_rdata[`FSDB_ST_OVERFLOW] = st_overflow;
            next_rdata[`FSDB_ST_OUT_RANGE] = st_range;
            next_rdata[`FSDB_ST_REFUSED] = st_refused;
         end
         default: begin
            // record words: byte 4k in bits 7:0
            if ((dp_addr >= `FSDB_A_REC_LO) && (dp_addr <= `FSDB_A_REC_HI) &&
               (dp_addr[1:0] == 2'b00)) begin
               next_rdata = rec[{word_sel, 5'b00000} +: 32];
            end
         end
      endcase
   end

   // read data is registered during the wait cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (dp_read && rd_wait) begin
         hrdata <= next_rdata;
      end
   end

endmodule

/* tb/fsdb_assertions.sv */
/*
 fsdb_assertions: port-level checks on the sense record stream and bus wait.
 assumes binding to fsdb_top, one clock, reset active high.
*/
`timescale 1ns/10ps

// ==========
// stream checker
module fsdb_assertions (
   input wire clk, // clock
   input wire rst, // async reset
   input wire hsel, // ahb select
   input wire [1:0] htrans, // ahb transfer type
   input wire hwrite, // ahb write
   input wire hready, // ahb bus ready
   input wire hreadyout, // ahb slave ready
   input wire [7:0] sense_byte, // record byte
   input wire sense_valid, // byte valid
   input wire sense_last, // last byte
   input wire sense_ready // host accepts
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   reg [4:0] idx;
   reg vbit;
   wire take = sense_valid && sense_ready;

   // byte index within the record and the valid flag seen in byte 0
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         idx <= 5'h0;
         vbit <= 1'b0;
      end else if (take) begin
         idx <= sense_last ? 5'h0 : idx + 5'h1;
         if (idx == 5'h0) begin
            vbit <= sense_byte[7];
         end
      end
   end

   chk_last_pos: assert property (sense_valid |-> (sense_last == (idx == 5'd31)))
      else $error("last flag not on byte 31");
   chk_rec_end: assert property (take && sense_last |=> !sense_valid)
      else $error("stream runs past the record");
   chk_byte_hold: assert property (sense_valid && !sense_ready |=>
      sense_valid && $stable(sense_byte) && $stable(sense_last))
      else $error("byte changed while stalled");
   chk_resp_code: assert property (sense_valid && idx == 5'd0 |->
      sense_byte[6:0] inside {7'h70, 7'h71})
      else $error("bad response code");
   chk_flag_zero: assert property (sense_valid && idx == 5'd2 |->
      sense_byte[7:6] == 2'b00 && !sense_byte[4])
      else $error("byte 2 spare bits set");
   chk_mm_valid: assert property (sense_valid && idx == 5'd2 && sense_byte[5] |-> vbit)
      else $error("mismatch without valid flag");
   chk_key_legal: assert property (sense_valid && idx == 5'd2 |->
      !(sense_byte[3:0] inside {4'h8, 4'ha, 4'hc, 4'hd, 4'hf}))
      else $error("unused sense key emitted");
   chk_info_zero: assert property (sense_valid && !vbit && idx inside {[5'd3:5'd6]} |->
      sense_byte == 8'h00)
      else $error("information bytes not zero");
   chk_add_len: assert property (sense_valid && idx == 5'd7 |-> sense_byte == 8'h18)
      else $error("additional length wrong");
   chk_csi_zero: assert property (sense_valid && idx inside {[5'd8:5'd11]} |->
      sense_byte == 8'h00)
      else $error("command info bytes not zero");
   chk_rsvd_zero: assert property (sense_valid &&
      idx inside {5'd1, 5'd14, 5'd18, 5'd19, 5'd30, 5'd31} |-> sense_byte == 8'h00)
      else $error("reserved byte not zero");
   chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
      !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");

   cov_deferred: cover property (sense_valid && idx == 5'd0 && sense_byte[6:0] == 7'h71);
   cov_mismatch: cover property (sense_valid && idx == 5'd2 && sense_byte[5]);
   cov_stall: cover property (sense_valid && !sense_ready ##1 take);
endmodule

bind fsdb_top fsdb_assertions u_fsdb_assertions (.clk(clk), .rst(rst), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .sense_byte(sense_byte), .sense_valid(sense_valid), .sense_last(sense_last),
   .sense_ready(sense_ready));

/* tb/fsdb_host_model.sv */
/*
 fsdb_host_model: initiator side taking the sense byte stream.
 assumes the stream ports of fsdb_top on the same clock.
*/
`timescale 1ns/10ps

// ==========
// host consumer
module fsdb_host_model (
   input wire clk,             // clock
   input wire rst,             // async reset
   input wire [7:0] sense_byte, // record byte
   input wire sense_valid,     // byte valid
   input wire sense_last,      // last byte
   input wire slow,            // stall every other cycle
   output reg sense_ready,     // accept
   output reg [255:0] rec,     // last record, byte n at [8n+7:8n]
   output reg [15:0] nrec,     // records completed
   output reg [15:0] nbyte     // bytes taken
);
   // capture accepted bytes; slow mode stalls to test holding
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sense_ready <= 1'b0;
         rec <= '0;
         nrec <= 16'h0;
         nbyte <= 16'h0;
      end else begin
         sense_ready <= slow ? ~sense_ready : 1'b1;
         if (sense_valid && sense_ready) begin
            rec[8*nbyte[4:0] +: 8] <= sense_byte;
            nbyte <= nbyte + 16'h1;
            if (sense_last) begin
               nrec <= nrec + 16'h1;
            end
         end
      end
   end
endmodule

/* tb/testbench.sv */
/*
 testbench: drives fsdb_top over ahb-lite and checks each sense record.
 assumes fsdb_defs.vh on the include path and the host model beside it.
*/
`timescale 1ns/10ps
`include "fsdb_defs.vh"

// ==========
// top
module testbench;
   logic clk, rst, hsel, hwrite, slow;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire hreadyout, hresp, sense_valid, sense_last, sense_ready, medium_hold;
   wire [31:0] hrdata;
   wire [7:0] sense_byte;
   wire [255:0] rec;
   wire [15:0] nrec, nbyte;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   localparam logic [31:0] KSP = 32'h00801234;
   localparam logic [31:0] VEN = 32'ha1b2c3d4;
   localparam logic [15:0] CODE = 16'h625d;
   // cfg, info_lo, info_hi, len, lba, blks, {hold,byte2,byte0}, info
   logic [31:0] tbl [0:10][0:7] = '{
      '{32'h2843, 32'h104, 32'h0, 32'h0, 32'h100, 32'h8, 32'h3f0, 32'h104},
      '{32'h31, 32'h1234, 32'h0, 32'h0, 32'h0, 32'h0, 32'h171, 32'h0},
      '{32'h12, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h270, 32'h0},
      '{32'h3e03, 32'h0, 32'h0, 32'h2100200, 32'h0, 32'h0, 32'h23f0, 32'hfffffff0},
      '{32'h3f46, 32'h10, 32'h0, 32'h2000200, 32'h10, 32'h1, 32'h6f0, 32'h10},
      '{32'h2800, 32'h0, 32'h0, 32'h3000200, 32'h0, 32'h0, 32'h70, 32'h0},
      '{32'h2847, 32'h5, 32'h1, 32'h0, 32'h0, 32'h10, 32'h770, 32'h0},
      '{32'h284b, 32'h108, 32'h0, 32'h0, 32'h100, 32'h8, 32'hb70, 32'h0},
      '{32'h745, 32'h9999, 32'h0, 32'h0, 32'h100, 32'h8, 32'h5f0, 32'h9999},
      '{32'h2880, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10570, 32'h0},
      '{32'h284e, 32'h107, 32'h0, 32'h0, 32'h100, 32'h8, 32'hef0, 32'h107}};

   fsdb_top u_fsdb_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense_byte(sense_byte),
      .sense_valid(sense_valid), .sense_last(sense_last), .sense_ready(sense_ready),
      .medium_hold(medium_hold));
   fsdb_host_model u_fsdb_host_model (.clk(clk), .rst(rst), .sense_byte(sense_byte),
      .sense_valid(sense_valid), .sense_last(sense_last), .slow(slow),
      .sense_ready(sense_ready), .rec(rec), .nrec(nrec), .nbyte(nbyte));

   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         end_of_test;
      end
   end

   // ==========
   // tasks
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp_r(input logic [255:0] g, input logic [255:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // wait for hready high at a rising edge, taking hrdata there
   task automatic rdy(output logic [31:0] d);
      logic s;
      do begin
         @(negedge clk);
         s = hreadyout;
         d = hrdata;
         @(posedge clk);
      end while (s !== 1'b1);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      hwrite <= w;
      htrans <= `FSDB_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      rdy(q);
      htrans <= 2'b00;
      hwdata <= d;
      rdy(q);
   endtask

   function automatic logic [255:0] exp_rec(input logic [7:0] b0, input logic [7:0] b2,
      input logic [31:0] inf);
      logic [255:0] r;
      r = '0;
      r[7:0] = b0;
      r[23:16] = b2;
      r[55:24] = {inf[7:0], inf[15:8], inf[23:16], inf[31:24]};
      r[63:56] = 8'h18;
      r[111:96] = CODE;
      r[143:120] = {KSP[7:0], KSP[15:8], KSP[23:16]};
      r[191:160] = {VEN[7:0], VEN[15:8], VEN[23:16], VEN[31:24]};
      return r;
   endfunction

   // build one record and compare the streamed copy and the first readable record word
   task automatic build(input logic [31:0] cfg, input logic [7:0] b0, input logic [7:0] b2,
      input logic [31:0] inf);
      logic [15:0] n0;
      logic [255:0] e;
      n0 = nrec;
      e = exp_rec(b0, b2, inf);
      bus(1'b1, `FSDB_A_CFG, cfg);
      bus(1'b1, `FSDB_A_CTRL, 32'h1);
      while (nrec === n0) @(posedge clk);
      cmp_r(rec, e);
      bus(1'b0, `FSDB_A_REC_LO, 32'h0);
      cmp_w(q, e[31:0]);
   endtask

   // ==========
   // main sequence
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = `FSDB_HSIZE_WORD;
      hwdata = 32'h0;
      slow = 1'b0;
      repeat (3) @(posedge clk);
      cmp_w({19'h0, hresp, hreadyout, sense_valid, sense_last, medium_hold, sense_byte},
         32'h800);
      cmp_w(hrdata, 32'h0);
      rst <= 1'b0;
      bus(1'b1, `FSDB_A_CODE, {16'h0, CODE});
      bus(1'b1, `FSDB_A_KSPEC, KSP);
      bus(1'b1, `FSDB_A_VENDOR, VEN);
      bus(1'b0, `FSDB_A_CODE, 32'h0);
      cmp_w(q, {16'h0, CODE});
      bus(1'b0, 8'h80, 32'h0);
      cmp_w(q, 32'h0);
      for (int i = 0; i < 11; i++) begin
         bus(1'b1, `FSDB_A_INFO_LO, tbl[i][1]);
         bus(1'b1, `FSDB_A_INFO_HI, tbl[i][2]);
         bus(1'b1, `FSDB_A_LEN, tbl[i][3]);
         bus(1'b1, `FSDB_A_CMD_LBA, tbl[i][4]);
         bus(1'b1, `FSDB_A_CMD_BLKS, tbl[i][5]);
         build(tbl[i][0], tbl[i][6][7:0], tbl[i][6][15:8], tbl[i][7]);
         cmp_w({31'h0, medium_hold}, {31'h0, tbl[i][6][16]});
      end
      // every key with a stalling host; unused keys become hardware error
      slow <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         build(k, 8'h70, (k inside {8, 10, 12, 13, 15}) ? 8'h04 : k, 32'h0);
      end
      // build requested while streaming is refused
      bus(1'b1, `FSDB_A_CTRL, 32'h1);
      bus(1'b1, `FSDB_A_CTRL, 32'h1);
      bus(1'b0, `FSDB_A_STATUS, 32'h0);
      cmp_w(q & 32'h20, 32'h20);
      bus(1'b0, `FSDB_A_STATUS, 32'h0);
      cmp_w(q & 32'h20, 32'h0);
      while (sense_valid === 1'b1) @(posedge clk);
      cmp_w({16'h0, nbyte}, {11'h0, nrec, 5'h0});
      // reset in mid record
      bus(1'b1, `FSDB_A_CFG, 32'h2880);
      bus(1'b1, `FSDB_A_CTRL, 32'h1);
      while (sense_valid !== 1'b1) @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      cmp_w({29'h0, sense_valid, medium_hold, hresp}, 32'h0);
      cmp_w(hrdata, 32'h0);
      end_of_test;
   end
endmodule
